// >>> tb/sar_adc_conversion_sequencer_test.sv
module sar_adc_conversion_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   reg clk = 1'b0, rst = 1'b1, reset_n = 1'b1, conv_start_n = 1'b1, cs_n = 1'b1, rd_n = 1'b1;
   reg use_internal_osc = 1'b0, neg_supply = 1'b0, result_ready = 1'b0;
   reg [7:0] dac_bus_word = 8'h00, vin = 8'h00;
   wire ext_conv_clk, comp_high, busy_n, int_n, hold, sample_strobe, osc_run, osc_clk, result_valid;
   wire [7:0] dac_code, approximation_register, data_out, result_data;
   integer err_count = 0, compares = 0, cycles = 0, i;
   reg [7:0] exp_q[$];
   initial forever #5 clk = ~clk;
   sarseq i_dut (.clk, .rst, .reset_n, .conv_start_n, .cs_n, .rd_n, .ext_conv_clk, .use_internal_osc,
      .neg_supply, .comp_high, .dac_bus_word, .dac_code, .approximation_register, .data_out, .busy_n,
      .int_n, .hold, .sample_strobe, .osc_run, .osc_clk, .result_valid, .result_ready, .result_data);
   sarseq_far_model i_far (.clk, .rst, .sample_strobe, .approximation_register, .vin, .ext_conv_clk,
      .comp_high);
   task conclude;
      begin
         $display("compares %0d, err_count %0d", compares, err_count);
         if (err_count == 0 && compares > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task check(input [95:0] what, input [7:0] exp, input [7:0] got);
      begin
         compares = compares + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %0s: expected %h, seen %h", what, exp, got);
         end
      end
   endtask
   task wait_busy(input lvl);
      integer n;
      begin
         n = 0;
         while (busy_n !== lvl && n < 400) begin
            @(posedge clk) #1;
            n = n + 1;
         end
         check("busy_n", lvl, busy_n);
      end
   endtask
   task conv(input rdst, input [7:0] v, input pulse);
      begin
         @(posedge clk) vin <= v;
         dac_bus_word <= ~v;
         @(posedge clk);
         if (rdst)
            {cs_n, rd_n} <= 2'b00;
         else
            conv_start_n <= 1'b0;
         wait_busy(1'b0);
         check("hold", 1'b1, hold);
         check("dac_code", ~v ^ {neg_supply, 7'h00}, dac_code);
         repeat (8) @(posedge clk);
         vin <= v ^ 8'h5a;
         if (pulse)
            reset_n <= 1'b0;
         @(posedge clk) reset_n <= 1'b1;
         wait_busy(1'b1);
         check("data_out", v ^ {neg_supply, 7'h00}, data_out);
         exp_q.push_back(v ^ {neg_supply, 7'h00});
         @(posedge clk) {cs_n, rd_n, conv_start_n} <= 3'b111;
         repeat (80) @(posedge clk);
      end
   endtask
   task drain;
      integer n;
      begin
         n = 0;
         result_ready <= 1'b1;
         while (exp_q.size() > 0 && n < 100) begin
            #1;
            if (result_valid === 1'b1)
               check("result_data", exp_q.pop_front(), result_data);
            @(posedge clk);
            n = n + 1;
         end
         result_ready <= 1'b0;
         #1 check("result_valid", 1'b0, result_valid);
         check("left", 8'h00, exp_q.size());
      end
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count = err_count + 1;
         conclude;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      conv(1'b0, 8'ha5, 1'b0);
      #1 check("int_n", 1'b0, int_n);
      @(posedge clk) cs_n <= 1'b0;
      @(posedge clk) cs_n <= 1'b1;
      repeat (4) @(posedge clk);
      #1 check("int_n", 1'b1, int_n);
      @(posedge clk) neg_supply <= 1'b1;
      conv(1'b1, 8'h3c, 1'b0);
      use_internal_osc <= 1'b1;
      conv(1'b0, 8'h01, 1'b1);
      use_internal_osc <= 1'b0;
      neg_supply <= 1'b0;
      drain;
      // result reader stalls (result_ready low) while the buffer fills
      for (i = 0; i < 16; i = i + 1)
         conv(1'b0, i * 16 + 15, 1'b0);
      #1 check("int_n", 1'b0, int_n);
      @(posedge clk) reset_n <= 1'b0;
      @(posedge clk) reset_n <= 1'b1;
      repeat (2) @(posedge clk);
      #1 check("int_n", 1'b1, int_n);
      @(posedge clk) conv_start_n <= 1'b0;
      repeat (20) @(posedge clk);
      #1 check("busy_n", 1'b1, busy_n);
      @(posedge clk) conv_start_n <= 1'b1;
      drain;
      conclude;
   end
endmodule

// >>> tb/sarseq_far_model.sv
module sarseq_far_model (
   input wire clk,
   input wire rst,
   input wire sample_strobe,
   input wire [7:0] approximation_register,
   input wire [7:0] vin,
   output reg ext_conv_clk,
   output wire comp_high
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [4:0] div;
   reg [7:0] held;
   // free running 200 ns clock, 50/50 mark/space
   always @(posedge clk) begin
      if (rst) begin
         div <= 5'h00;
         ext_conv_clk <= 1'b1;
         held <= 8'h00;
      end else begin
         div <= (div == 5'h13) ? 5'h00 : div + 5'h01;
         if (div == 5'h09 || div == 5'h13)
            ext_conv_clk <= ~ext_conv_clk;
         if (sample_strobe)
            held <= vin;
      end
   end
   // compares the held sample, so a late input change must not matter
   assign comp_high = held >= approximation_register;
endmodule

// >>> tb/sarseq_props.sv
module sarseq_props (
   input wire clk,
   input wire rst,
   input wire reset_n,
   input wire rd_n,
   input wire [7:0] approximation_register,
   input wire [7:0] data_out,
   input wire busy_n,
   input wire int_n,
   input wire hold,
   input wire sample_strobe,
   input wire osc_run,
   input wire osc_clk
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_hold_busy: assert property (!busy_n |-> hold)
      else $error("hold low in conversion");
   a_sample_time: assert property ($fell(busy_n) |-> ##5 sample_strobe)
      else $error("sample moment off");
   a_msb_trial: assert property ($fell(busy_n) |-> approximation_register == 8'h80)
      else $error("first trial word off");
   a_latch_keep: assert property (!busy_n |-> $stable(data_out))
      else $error("latch moved in conversion");
   a_end_clear: assert property ($rose(busy_n) |-> approximation_register == 8'h00 && !hold && !osc_run)
      else $error("end state off");
   a_int_end: assert property ($rose(busy_n) && reset_n |=> !int_n)
      else $error("int_n not set at end");
   a_int_reset: assert property (!reset_n && !$rose(busy_n) |-> ##[1:3] int_n)
      else $error("int_n kept by reset pin");
   a_int_strobe: assert property ($rose(rd_n) && busy_n && $past(busy_n) |-> ##[1:3] int_n)
      else $error("int_n kept by strobe");
   a_osc_idle: assert property (busy_n [*3] |-> !osc_clk)
      else $error("oscillator runs idle");
   a_conv_len: assert property ($fell(busy_n) |-> ##[150:240] $rose(busy_n))
      else $error("conversion length off");
endmodule

bind sarseq sarseq_props i_props (.clk, .rst, .reset_n, .rd_n, .approximation_register, .data_out, .busy_n,
   .int_n, .hold, .sample_strobe, .osc_run, .osc_clk);

// >>> verilog/sarseq.v
// Overview of operation
// - binary or twos complement per supply strap
// - start on start fall or select-read low
// - reset pin clears interrupt, not conversion
// - uncleared interrupt never stalls conversions
// - sample captured 50 ns after start
// - msb decided 50 ns after second edge
// - edges within 50 ns of start skipped
// - later bits decided 50 ns after edges
// - copy approximation to latch, then clear
// - eight clock cycles, eight-bit parallel result
// - hold at start, track when busy rises
// - internal oscillator stops after conversion ends
// - two microsecond conversion at nominal clock
// - busy low for whole conversion
// - interrupt low at end, cleared by strobes
// - start line acts without device select
`include "sarseq_regs.vh"

module sarseq_fifo #(
   parameter WIDTH = `SARSEQ_BITS,
   parameter DEPTH = `SARSEQ_FIFO_DEPTH,
   parameter AW = `SARSEQ_FIFO_AW
) (
   input wire clk,
   input wire rst,
   input wire in_valid,
   output reg in_ready,
   input wire [WIDTH-1:0] in_data,
   output reg out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   wire [AW-1:0] next_rd;
   reg [AW:0] next_count;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign next_rd = pop ? rd_ptr + 1'b1 : rd_ptr;

   always @* begin
      next_count = count;
      if (push & ~pop) begin
         next_count = count + 1'b1;
      end else if (pop & ~push) begin
         next_count = count - 1'b1;
      end
   end

   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // registered read port keeps the result bus straight off a flop
   // a word pushed into an empty buffer bypasses the array
   always @(posedge clk) begin
      if (rst) begin
         out_data <= {WIDTH{1'b0}};
      end else if (push & (next_rd == wr_ptr)) begin
         out_data <= in_data;
      end else begin
         out_data <= mem[next_rd];
      end
   end

   // flags registered so the ports come from flip-flops
   always @(posedge clk) begin
      if (rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
         in_ready <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         count <= next_count;
         in_ready <= (next_count != DEPTH[AW:0]);
         out_valid <= (next_count != {(AW+1){1'b0}});
      end
   end
endmodule

module sarseq #(
   parameter BITS = `SARSEQ_BITS,
   parameter EDGE_DELAY = `SARSEQ_EDGE_DELAY_CYC,
   parameter OSC_HALF = `SARSEQ_OSC_HALF_CYC
) (
   input wire clk,
   input wire rst,
   input wire reset_n,
   input wire conv_start_n,
   input wire cs_n,
   input wire rd_n,
   input wire ext_conv_clk,
   input wire use_internal_osc,
   input wire neg_supply,
   input wire comp_high,
   input wire [BITS-1:0] dac_bus_word,
   output reg [BITS-1:0] dac_code,
   output reg [BITS-1:0] approximation_register,
   output reg [BITS-1:0] data_out,
   output reg busy_n,
   output reg int_n,
   output reg hold,
   output reg sample_strobe,
   output reg osc_run,
   output reg osc_clk,
   output wire result_valid,
   input wire result_ready,
   output wire [BITS-1:0] result_data
);
   reg [1:0] state;
   reg start_prev_n;
   reg csrd_prev;
   reg cs_prev_n;
   reg rd_prev_n;
   reg clk_prev;
   reg [7:0] win_cnt;
   reg [7:0] dec_cnt;
   reg dec_pend;
   reg [3:0] bit_idx;
   reg [7:0] samp_cnt;
   reg [7:0] osc_cnt;
   reg push_valid;
   reg [BITS-1:0] push_data;
   wire fifo_ready;
   wire csrd_low;
   wire start_req;
   wire conv_clk_sel;
   wire conv_fall;
   wire strobe_rise;
   reg [BITS-1:0] next_approx;

   // msb inversion maps offset binary to twos complement and back
   function [BITS-1:0] fmt;
      input [BITS-1:0] word;
      input neg;
      begin
         fmt = neg ? {~word[BITS-1], word[BITS-2:0]} : word;
      end
   endfunction

   // one decode for the start, shared by the sequencer and the sample timer
   function start_ok;
      input [1:0] st;
      input req;
      input room;
      begin
         start_ok = (st == `SARSEQ_ST_IDLE) & req & room;
      end
   endfunction

   assign csrd_low = ~cs_n & ~rd_n;
   // start line is deliberately not qualified by select
   assign start_req = (start_prev_n & ~conv_start_n) | (csrd_low & ~csrd_prev);
   assign conv_clk_sel = use_internal_osc ? osc_clk : ext_conv_clk;
   assign conv_fall = clk_prev & ~conv_clk_sel;
   assign strobe_rise = (~cs_prev_n & cs_n) | (~rd_prev_n & rd_n);

   always @* begin
      next_approx = approximation_register;
      if (~comp_high) begin
         next_approx[bit_idx[2:0]] = 1'b0;
      end
      if (bit_idx != 4'h0) begin
         next_approx[bit_idx[2:0] - 3'h1] = 1'b1;
      end
   end

   // dac word follows the same format strap as the result
   always @(posedge clk) begin
      if (rst) begin
         dac_code <= `SARSEQ_RST_WORD;
      end else begin
         dac_code <= fmt(dac_bus_word, neg_supply);
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         start_prev_n <= 1'b1;
         csrd_prev <= 1'b0;
         cs_prev_n <= 1'b1;
         rd_prev_n <= 1'b1;
         clk_prev <= 1'b0;
      end else begin
         start_prev_n <= conv_start_n;
         csrd_prev <= csrd_low;
         cs_prev_n <= cs_n;
         rd_prev_n <= rd_n;
         clk_prev <= conv_clk_sel;
      end
   end

   // internal oscillator runs only while converting
   // restarts low, so its first fall comes a full period in
   always @(posedge clk) begin
      if (rst) begin
         osc_cnt <= 8'h00;
         osc_clk <= 1'b0;
      end else if (~osc_run) begin
         osc_cnt <= 8'h00;
         osc_clk <= 1'b0;
      end else if (osc_cnt == OSC_HALF[7:0] - 8'h01) begin
         osc_cnt <= 8'h00;
         osc_clk <= ~osc_clk;
      end else begin
         osc_cnt <= osc_cnt + 8'h01;
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         state <= `SARSEQ_ST_IDLE;
         approximation_register <= `SARSEQ_RST_WORD;
         data_out <= `SARSEQ_RST_WORD;
         busy_n <= `SARSEQ_RST_BUSY_N;
         hold <= 1'b0;
         osc_run <= 1'b0;
         win_cnt <= 8'h00;
         dec_cnt <= 8'h00;
         dec_pend <= 1'b0;
         bit_idx <= 4'h0;
         push_valid <= 1'b0;
         push_data <= `SARSEQ_RST_WORD;
      end else begin
         push_valid <= 1'b0;
         case (state)
            `SARSEQ_ST_IDLE: begin
               // starts during a conversion are ignored; a start while the fifo is full is dropped, not held
               if (start_ok(state, start_req, fifo_ready)) begin
                  state <= `SARSEQ_ST_ARM;
                  busy_n <= 1'b0;
                  hold <= 1'b1;
                  osc_run <= use_internal_osc;
                  win_cnt <= 8'h00;
                  dec_pend <= 1'b0;
                  bit_idx <= BITS[3:0] - 4'h1;
                  approximation_register <= `SARSEQ_TRIAL_MSB;
               end
            end
            `SARSEQ_ST_ARM: begin
               // a falling edge too close to the start is not counted
               if (win_cnt < EDGE_DELAY[7:0]) begin
                  win_cnt <= win_cnt + 8'h01;
               end else if (conv_fall) begin
                  state <= `SARSEQ_ST_CONV;
               end
            end
            `SARSEQ_ST_CONV: begin
               // a fall before the decision is due restarts its delay
               if (conv_fall) begin
                  dec_pend <= 1'b1;
                  dec_cnt <= EDGE_DELAY[7:0] - 8'h01;
               end else if (dec_pend) begin
                  if (dec_cnt != 8'h00) begin
                     dec_cnt <= dec_cnt - 8'h01;
                  end else begin
                     dec_pend <= 1'b0;
                     if (bit_idx == 4'h0) begin
                        // one decision per cycle, eight cycles total
                        data_out <= fmt(next_approx, neg_supply);
                        push_data <= fmt(next_approx, neg_supply);
                        push_valid <= 1'b1;
                        approximation_register <= `SARSEQ_RST_WORD;
                        busy_n <= 1'b1;
                        hold <= 1'b0;
                        osc_run <= 1'b0;
                        state <= `SARSEQ_ST_IDLE;
                     end else begin
                        approximation_register <= next_approx;
                        bit_idx <= bit_idx - 4'h1;
                     end
                  end
               end
            end
            default: begin
               state <= `SARSEQ_ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (rst) begin
         samp_cnt <= 8'h00;
         sample_strobe <= 1'b0;
      end else begin
         sample_strobe <= 1'b0;
         // counted from the very cycle the start is taken
         if (start_ok(state, start_req, fifo_ready)) begin
            samp_cnt <= EDGE_DELAY[7:0];
         end else if (samp_cnt != 8'h00) begin
            samp_cnt <= samp_cnt - 8'h01;
            sample_strobe <= (samp_cnt == 8'h01);
         end
      end
   end

   // end of conversion wins over a clear in the same cycle
   always @(posedge clk) begin
      if (rst) begin
         int_n <= `SARSEQ_RST_INT_N;
      end else if (push_valid) begin
         int_n <= 1'b0;
      end else if (strobe_rise | ~reset_n) begin
         int_n <= 1'b1;
      end
   end

   sarseq_fifo #(
      .WIDTH(BITS),
      .DEPTH(`SARSEQ_FIFO_DEPTH),
      .AW(`SARSEQ_FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(fifo_ready),
      .in_data(push_data),
      .out_valid(result_valid),
      .out_ready(result_ready),
      .out_data(result_data)
   );
endmodule

// >>> verilog/sarseq_regs.vh
`ifndef SARSEQ_REGS_VH
`define SARSEQ_REGS_VH

`define SARSEQ_CLK_MHZ 100
`define SARSEQ_BITS 8
`define SARSEQ_CONV_CYCLES 8
`define SARSEQ_CONV_TIME_NS 2000
`define SARSEQ_EDGE_DELAY_NS 50
`define SARSEQ_EDGE_DELAY_CYC ((`SARSEQ_EDGE_DELAY_NS * `SARSEQ_CLK_MHZ + 999) / 1000)
`define SARSEQ_BIT_PERIOD_NS (`SARSEQ_CONV_TIME_NS / `SARSEQ_CONV_CYCLES)
`define SARSEQ_OSC_HALF_CYC ((`SARSEQ_BIT_PERIOD_NS * `SARSEQ_CLK_MHZ) / 2000)
`define SARSEQ_FIFO_DEPTH 16
`define SARSEQ_FIFO_AW 4

`define SARSEQ_ST_IDLE 2'h0
`define SARSEQ_ST_ARM 2'h1
`define SARSEQ_ST_CONV 2'h2

`define SARSEQ_RST_WORD 8'h00
`define SARSEQ_TRIAL_MSB 8'h80
`define SARSEQ_RST_INT_N 1'b1
`define SARSEQ_RST_BUSY_N 1'b1

`endif
